// ==== logic/main_ctrl_reg.sv ====
// Purpose: main control register with watchdog and global enables
// Assumes: frame words arrive on mclk as one-cycle valid pulses
// Notes:   per-channel control lives elsewhere
`timescale 1ns/10ps
module main_ctrl_reg #(
  parameter int WD_CYC0 = main_ctrl_pkg::WD_MS0 * main_ctrl_pkg::CYC_PER_MS,
  parameter int WD_CYC1 = main_ctrl_pkg::WD_MS1 * main_ctrl_pkg::CYC_PER_MS,
  parameter int WD_CYC2 = main_ctrl_pkg::WD_MS2 * main_ctrl_pkg::CYC_PER_MS,
  parameter int WD_CYC3 = main_ctrl_pkg::WD_MS3 * main_ctrl_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // decoded serial frames
  input  wire main_ctrl_pkg::frame_t frameIn,
  // output-level pin, asynchronous
  input  wire logic                  outLevelPin,
  // per-channel enables from the channel control registers
  input  wire logic [3:0]            chanOutEn,
  input  wire logic [3:0]            chanConvPower,
  // results
  output main_ctrl_pkg::main_ctrl_t  mainCtrl,
  output logic [15:0]                mainCtrlWord,
  output logic                       disabledLevel,
  output logic                       shortLimit8mA,
  output logic [3:0]                 outEnable,
  output logic [3:0]                 convPowerUp,
  output logic                       statusOnWrite,
  output logic                       watchdogTimeout
);
  import main_ctrl_pkg::*;

  // -------------------------------------------------------------------
  // write decode
  // -------------------------------------------------------------------
  main_ctrl_t  ctrl_q;
  logic        wrMain;
  logic [15:0] pay;
  assign pay    = frameIn.word[15:0];
  assign wrMain = frameIn.valid && !frameIn.word[RW_BIT]
                && frameIn.word[DSEL_HI:DSEL_LO] == DSEL_CTRL
                && frameIn.word[CSEL_HI:CSEL_LO] == CSEL_MAIN;

  // D7 and D3..D0 are never stored
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= '0;
    end else if (wrMain) begin
      ctrl_q <= {pay[B_LEVEL], pay[B_STAT], pay[B_WDEN], pay[B_WDHI],
                 pay[B_WDLO], pay[B_SHORT], pay[B_OUTALL],
                 pay[B_DCALL]};
    end
  end
  assign mainCtrl     = ctrl_q;
  assign mainCtrlWord = {CSEL_MAIN, ctrl_q[7:3], 1'h0, ctrl_q[2:0], 4'h0};

  // -------------------------------------------------------------------
  // pin synchroniser and output level
  // -------------------------------------------------------------------
  logic pinMeta_q;
  logic pinSync_q;
  logic level_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_q <= 1'h0;
      pinSync_q <= 1'h0;
    end else begin
      pinMeta_q <= outLevelPin;
      pinSync_q <= pinMeta_q;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 1'h0;
    end else begin
      level_q <= pinSync_q ^ ctrl_q.disabledOutputLevelSelect;
    end
  end
  assign disabledLevel = level_q;
  assign shortLimit8mA = ctrl_q.shortCircuitLimitSelect;
  assign statusOnWrite = ctrl_q.statusReadbackEnable;

  // -------------------------------------------------------------------
  // global enables: one register update hits every channel at once
  // -------------------------------------------------------------------
  logic [3:0] channel_output_enable_q;
  logic [3:0] conv_q;
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          channel_output_enable_q[i] <= 1'h0;
          conv_q[i]  <= 1'h0;
        end else begin
          channel_output_enable_q[i] <= chanOutEn[i] | ctrl_q.allOutputsEnable;
          conv_q[i]  <= chanConvPower[i]
                      | ctrl_q.allConvertersPowerUp;
        end
      end
    end
  endgenerate
  assign outEnable   = channel_output_enable_q;
  assign convPowerUp = conv_q;

  // -------------------------------------------------------------------
  // watchdog: any valid frame restarts the count
  // -------------------------------------------------------------------
  logic [23:0] wdCnt_q;
  logic        wdTo_q;
  logic [23:0] wdLimit;
  always_comb begin
    case ({ctrl_q.watchdogTimeoutSelHi, ctrl_q.watchdogTimeoutSelLo})
      2'h0:    wdLimit = 24'(WD_CYC0);
      2'h1:    wdLimit = 24'(WD_CYC1);
      2'h2:    wdLimit = 24'(WD_CYC2);
      default: wdLimit = 24'(WD_CYC3);
    endcase
  end
  // a frame in the timeout cycle wins: the host was still in time
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdCnt_q <= '0;
      wdTo_q  <= 1'h0;
    end else if (!ctrl_q.watchdogEnable || frameIn.valid) begin
      wdCnt_q <= '0;
      wdTo_q  <= 1'h0;
    end else if (wdCnt_q >= wdLimit - 24'h1) begin
      wdTo_q  <= 1'h1;
    end else begin
      wdCnt_q <= wdCnt_q + 24'h1;
    end
  end
  assign watchdogTimeout = wdTo_q;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  // global bits OR into the channel bits; host misuse is not flagged
  property p_store;
    @(posedge mclk) disable iff (!reset_n)
      wrMain |=> ctrl_q.watchdogEnable == $past(pay[B_WDEN]);
  endproperty
  a_store: assert property (p_store) else $error("store failed");
  property p_ignore;
    @(posedge mclk) disable iff (!reset_n)
      !wrMain |=> $stable(ctrl_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("stray write");
  property p_level;
    @(posedge mclk) disable iff (!reset_n)
      ##1 disabledLevel == ($past(pinSync_q) ^ $past(ctrl_q[7]));
  endproperty
  a_level: assert property (p_level) else $error("level wrong");
  property p_stat;
    @(posedge mclk) disable iff (!reset_n)
      wrMain |=> statusOnWrite == $past(pay[B_STAT]);
  endproperty
  a_stat: assert property (p_stat) else $error("readback wrong");
  property p_wdoff;
    @(posedge mclk) disable iff (!reset_n)
      !ctrl_q.watchdogEnable |=> !watchdogTimeout;
  endproperty
  a_wdoff: assert property (p_wdoff) else $error("wd while off");
  property p_wdsel;
    @(posedge mclk) disable iff (!reset_n)
      $rose(watchdogTimeout) |-> $past(wdCnt_q) >= wdLimit - 24'h1;
  endproperty
  a_wdsel: assert property (p_wdsel) else $error("wd early");
  property p_short;
    @(posedge mclk) disable iff (!reset_n)
      wrMain |=> shortLimit8mA == $past(pay[B_SHORT]);
  endproperty
  a_short: assert property (p_short) else $error("limit wrong");
  property p_outall;
    @(posedge mclk) disable iff (!reset_n)
      ctrl_q.allOutputsEnable |=> outEnable == 4'hF;
  endproperty
  a_outall: assert property (p_outall) else $error("outs not all");
  property p_dcall;
    @(posedge mclk) disable iff (!reset_n)
      ctrl_q.allConvertersPowerUp |=> convPowerUp == 4'hF;
  endproperty
  a_dcall: assert property (p_dcall) else $error("convs not all");
  property p_dont;
    @(posedge mclk) disable iff (!reset_n)
      wrMain |=> mainCtrlWord == ($past(pay) & MC_MASK);
  endproperty
  a_dont: assert property (p_dont) else $error("ignored bits kept");
  property p_rdnone;
    @(posedge mclk) disable iff (!reset_n)
      frameIn.valid && frameIn.word[RW_BIT] |=> $stable(mainCtrlWord);
  endproperty
  a_rdnone: assert property (p_rdnone) else $error("read wrote");
  property p_wdkick;
    @(posedge mclk) disable iff (!reset_n)
      frameIn.valid |=> !watchdogTimeout && wdCnt_q == 24'h0;
  endproperty
  a_wdkick: assert property (p_wdkick) else $error("wd not kicked");
  property p_wdhold;
    @(posedge mclk) disable iff (!reset_n)
      watchdogTimeout && ctrl_q.watchdogEnable && !frameIn.valid
      |=> watchdogTimeout;
  endproperty
  a_wdhold: assert property (p_wdhold) else $error("wd dropped");
  property p_wdbound;
    @(posedge mclk) disable iff (!reset_n)
      wdCnt_q < wdLimit;
  endproperty
  a_wdbound: assert property (p_wdbound) else $error("wd overrun");
  property p_outfollow;
    @(posedge mclk) disable iff (!reset_n)
      !ctrl_q.allOutputsEnable |=> outEnable == $past(chanOutEn);
  endproperty
  a_outfollow: assert property (p_outfollow) else $error("outs wrong");
  property p_convfollow;
    @(posedge mclk) disable iff (!reset_n)
      !ctrl_q.allConvertersPowerUp |=> convPowerUp == $past(chanConvPower);
  endproperty
  a_convfollow: assert property (p_convfollow) else $error("conv wrong");
  c_write: cover property (@(posedge mclk) wrMain);
  c_wdto:  cover property (@(posedge mclk) $rose(watchdogTimeout));
  c_all:   cover property (@(posedge mclk) outEnable == 4'hF);
  c_level: cover property (@(posedge mclk) $rose(disabledLevel));
  c_conv:  cover property (@(posedge mclk) convPowerUp == 4'hF);
endmodule

// ==== logic/main_ctrl_pkg.sv ====
// Purpose: constants and carrier types for the main control register
// Assumes: frames are already deserialised into 24-bit words
// Notes:   one clock, mclk at 40 MHz
package main_ctrl_pkg;
  // -------------------------------------------------------------------
  // frame layout
  // -------------------------------------------------------------------
  localparam int          DSEL_HI     = 20;
  localparam int          DSEL_LO     = 18;
  localparam int          CSEL_HI     = 15;
  localparam int          CSEL_LO     = 13;
  localparam logic [2:0]  DSEL_CTRL   = 3'h7;
  localparam logic [2:0]  CSEL_MAIN   = 3'h1;
  localparam int          RW_BIT      = 23;
  // -------------------------------------------------------------------
  // main control fields
  // -------------------------------------------------------------------
  localparam int          B_LEVEL     = 12;
  localparam int          B_STAT      = 11;
  localparam int          B_WDEN      = 10;
  localparam int          B_WDHI      = 9;
  localparam int          B_WDLO      = 8;
  localparam int          B_SHORT     = 6;
  localparam int          B_OUTALL    = 5;
  localparam int          B_DCALL     = 4;
  localparam int          NCH         = 4;
  // -------------------------------------------------------------------
  // watchdog timing
  // -------------------------------------------------------------------
  localparam int          CLK_HZ      = 40000000;
  localparam int          WD_MS0      = 5;
  localparam int          WD_MS1      = 10;
  localparam int          WD_MS2      = 100;
  localparam int          WD_MS3      = 200;
  localparam int          CYC_PER_MS  = CLK_HZ / 1000;
  localparam logic [15:0] MC_RESET    = 16'h2000;
  // bits that the readback image keeps; D7 and D3..D0 read as zero
  localparam logic [15:0] MC_MASK     = 16'hFF70;

  typedef struct packed {
    logic       disabledOutputLevelSelect;
    logic       statusReadbackEnable;
    logic       watchdogEnable;
    logic       watchdogTimeoutSelHi;
    logic       watchdogTimeoutSelLo;
    logic       shortCircuitLimitSelect;
    logic       allOutputsEnable;
    logic       allConvertersPowerUp;
  } main_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] word;
  } frame_t;
endpackage

// ==== testbench/host_model.sv ====
// Purpose: host model writing deserialised frames and channel levels
// Assumes: one frame word per valid pulse
// Notes:   released word lines show the inverse of the last word
`timescale 1ns/10ps
module host_model (
  // clock
  input  wire logic                  mclk,
  // frames and per-channel levels
  output main_ctrl_pkg::frame_t      frameIn,
  output logic [3:0]                 chanOutEn,
  output logic [3:0]                 chanConvPower
);
  import main_ctrl_pkg::*;
  logic [15:0] mainQ;

  initial begin
    frameIn = '0;
    chanOutEn = 4'h0;
    chanConvPower = 4'h0;
    mainQ = MC_RESET;
  end

  task automatic send(input logic rd, input logic [2:0] dataSel,
                      input logic [15:0] p);
    if (!rd && dataSel == DSEL_CTRL && p[15:13] == CSEL_MAIN) begin
      mainQ = p;
    end
    @(posedge mclk);
    frameIn <= '{1'h1, {rd, 2'h0, dataSel, 2'h0, p}};
    @(posedge mclk);
    frameIn <= '{1'h0, ~{rd, 2'h0, dataSel, 2'h0, p}};
  endtask

  // per-channel bits stay off while the global bits are in use
  task automatic set_chan(input logic [3:0] en, input logic [3:0] cp);
    @(posedge mclk);
    chanOutEn <= mainQ[B_OUTALL] ? 4'h0 : en;
    chanConvPower <= mainQ[B_DCALL] ? 4'h0 : cp;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the main control register
// Assumes: short watchdog counts of 20, 40, 80 and 160 cycles
// Notes:   expectations come from the field layout only
`timescale 1ns/10ps
module tb_top;
  import main_ctrl_pkg::*;
  // watchdog limit in cycles for each timeout code, as set at uut
  function automatic int lim(input int i);
    case (i)
      0: return 20;
      1: return 40;
      2: return 80;
      default: return 160;
    endcase
  endfunction
  logic       mclk, reset_n, outLevelPin;
  frame_t     frameIn;
  logic [3:0] chanOutEn, chanConvPower, outEnable, convPowerUp;
  main_ctrl_t mainCtrl;
  logic [15:0] mainCtrlWord;
  logic       disabledLevel, shortLimit8mA, statusOnWrite, watchdogTimeout;
  int         badCount, comparisons;

  host_model hm (.mclk(mclk), .frameIn(frameIn), .chanOutEn(chanOutEn),
    .chanConvPower(chanConvPower));
  main_ctrl_reg #(.WD_CYC0(20), .WD_CYC1(40), .WD_CYC2(80), .WD_CYC3(160))
  uut (.mclk(mclk), .reset_n(reset_n), .frameIn(frameIn),
    .outLevelPin(outLevelPin), .chanOutEn(chanOutEn),
    .chanConvPower(chanConvPower), .mainCtrl(mainCtrl),
    .mainCtrlWord(mainCtrlWord), .disabledLevel(disabledLevel),
    .shortLimit8mA(shortLimit8mA), .outEnable(outEnable),
    .convPowerUp(convPowerUp), .statusOnWrite(statusOnWrite),
    .watchdogTimeout(watchdogTimeout));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #50000;
    badCount++;
    finish_test;
  end

  initial begin
    badCount = 0;
    comparisons = 0;
    reset_n = 1'h0;
    outLevelPin = 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    #1;
    check(mainCtrlWord, 16'h2000);
    check({8'h00, mainCtrl}, 16'h0000);
    // all fields plus the ignored bits set
    hm.send(1'h0, DSEL_CTRL, 16'h3FFF);
    wt(2);
    check(mainCtrlWord, 16'h3F70);
    check({8'h00, mainCtrl}, 16'h00FF);
    check({8'h00, outEnable, convPowerUp}, 16'h00FF);
    check({14'h0, shortLimit8mA, statusOnWrite}, 16'h0003);
    // read, other data selector, other control selector: all ignored
    hm.send(1'h1, DSEL_CTRL, 16'h2000);
    hm.send(1'h0, 3'h6, 16'h2000);
    hm.send(1'h0, DSEL_CTRL, 16'h4000);
    wt(2);
    check(mainCtrlWord, 16'h3F70);
    hm.send(1'h0, DSEL_CTRL, 16'h2010);
    hm.send(1'h0, DSEL_CTRL, 16'h2000);
    wt(2);
    check({8'h00, outEnable, convPowerUp}, 16'h0000);
    hm.set_chan(4'h5, 4'hA);
    wt(2);
    check({8'h00, outEnable, convPowerUp}, 16'h005A);
    hm.set_chan(4'h0, 4'h0);
    @(posedge mclk);
    outLevelPin <= 1'h1;
    wt(5);
    check({15'h0, disabledLevel}, 16'h0001);
    hm.send(1'h0, DSEL_CTRL, 16'h3000);
    wt(2);
    check({15'h0, disabledLevel}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      hm.send(1'h0, DSEL_CTRL, 16'h2400 | (16'(i) << 8));
      wt(lim(i) / 2);
      check({15'h0, watchdogTimeout}, 16'h0000);
      wt(lim(i));
      check({15'h0, watchdogTimeout}, 16'h0001);
    end
    // disabling stops the count for good, not only until the next frame
    hm.send(1'h0, DSEL_CTRL, 16'h2000);
    wt(2);
    check({15'h0, watchdogTimeout}, 16'h0000);
    wt(200);
    check({15'h0, watchdogTimeout}, 16'h0000);
    // reset in mid-run brings back the defaults
    hm.send(1'h0, DSEL_CTRL, 16'h3FFF);
    @(posedge mclk);
    reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    #1;
    check(mainCtrlWord, 16'h2000);
    check({8'h00, outEnable, convPowerUp}, 16'h0000);
    finish_test;
  end
endmodule
